/* File: core/read_prefetch_ctl.sv */
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
module read_prefetch_ctl #(
  parameter int unsigned DISCARD_CYCLES = prefetch_pkg::DISCARD_CYCLES_DEF
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        req_valid,
  input  wire logic [3:0]  req_cmd,
  input  wire logic [31:0] req_addr,
  input  wire logic [3:0]  req_be,
  output logic             req_ready,
  input  wire logic        xfer_end,
  input  wire logic        end_by_master,
  output logic             retry_pulse,
  output logic             hit_pulse,
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic      [31:0] rd_addr,
  output logic      [12:0] rd_len,
  output logic             rd_type1,
  output logic             rd_cfg,
  output logic             rd_predict,
  output logic             rd_disc1,
  output logic             malformed_chk_en,
  output logic             discard_pulse
);
  logic [31:0] ctl_q;
  logic [31:0] wbase_q;
  logic [31:0] wlimit_q;
  logic        tmo_q;
  logic        ap_wr_q;
  logic [7:0]  ap_addr_q;
  logic        ap_valid;
  logic        wr_en;
  logic        is_mr;
  logic        is_mrl;
  logic        is_mrm;
  logic        is_cfg;
  logic        is_mem;
  logic        dly_is_mem;
  logic        in_win;
  logic [1:0]  mode;
  logic        full;
  logic        conv;
  logic        match;
  logic        hit;
  logic        fwd;
  logic        keep;
  logic        expire;
  logic        dly_v_q;
  logic [3:0]  dly_cmd_q;
  logic [31:0] dly_addr_q;
  logic [3:0]  dly_be_q;
  logic [1:0]  dly_mode_q;
  logic        dly_full_q;
  logic        ret_q;
  logic [31:0] tmr_q;
  logic [31:0] rdmux;

  rd_req_if in_if ();
  rd_req_if out_if ();

  req_buf2 u_buf (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .enq     (in_if.snk),
    .deq     (out_if.src)
  );

  // Bus slave answers at once and always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_valid  = hsel & htrans[1] & hready;
  assign wr_en     = ap_wr_q & hready;

  // Address phase capture
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (hready) begin
      ap_wr_q   <= ap_valid & hwrite & (haddr[31:8] == 24'h00_0000); // Aliases are not mapped
      ap_addr_q <= haddr[7:0];
    end
  end

  // Read data mux, zero for unmapped words
  always_comb begin
    rdmux = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000) begin
      unique case (haddr[7:0])
        prefetch_pkg::OFF_CTL:    rdmux = ctl_q;
        prefetch_pkg::OFF_WBASE:  rdmux = wbase_q;
        prefetch_pkg::OFF_WLIMIT: rdmux = wlimit_q;
        prefetch_pkg::OFF_STAT: begin
          rdmux[prefetch_pkg::STAT_TMO] = tmo_q;
          rdmux[prefetch_pkg::STAT_RET] = ret_q;
        end
        default:                  rdmux = 32'h0000_0000;
      endcase
    end
  end

  // Read data registered in the address phase, stands in the data phase
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hrdata <= rdmux;
    end
  end

  // Control and window registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctl_q    <= prefetch_pkg::CTL_RST;
      wbase_q  <= prefetch_pkg::WBASE_RST;
      wlimit_q <= prefetch_pkg::WLIMIT_RST;
    end else if (wr_en) begin
      unique case (ap_addr_q)
        prefetch_pkg::OFF_CTL:    ctl_q    <= hwdata & prefetch_pkg::CTL_MASK;
        prefetch_pkg::OFF_WBASE:  wbase_q  <= hwdata;
        prefetch_pkg::OFF_WLIMIT: wlimit_q <= hwdata;
        default: ;
      endcase
    end
  end

  assign malformed_chk_en = ctl_q[prefetch_pkg::BIT_MAL];

  // Command decode and prefetch mode selection
  assign is_mr  = req_cmd == prefetch_pkg::CMD_MR;
  assign is_mrl = req_cmd == prefetch_pkg::CMD_MRL;
  assign is_mrm = req_cmd == prefetch_pkg::CMD_MRM;
  assign is_cfg = req_cmd[3:1] == prefetch_pkg::CMD_CFG;
  assign is_mem = is_mr | is_mrl | is_mrm;
  assign dly_is_mem = dly_cmd_q == prefetch_pkg::CMD_MR || dly_cmd_q == prefetch_pkg::CMD_MRL
                      || dly_cmd_q == prefetch_pkg::CMD_MRM;
  assign in_win = is_mem && req_addr >= wbase_q && req_addr <= wlimit_q;
  assign mode   = is_mrm ? ctl_q[prefetch_pkg::MRM_LSB +: 2]
                : is_mrl ? ctl_q[prefetch_pkg::MRL_LSB +: 2]
                : ctl_q[prefetch_pkg::MR_LSB +: 2];
  // Plain reads fetch full only on 10; the 01 code is reserved there
  assign full   = in_win & (is_mr ? mode == prefetch_pkg::PF_FULL
                                  : mode != prefetch_pkg::PF_LINE);
  assign conv   = is_cfg & ctl_q[prefetch_pkg::BIT_CONV]
                & (req_addr[31:28] == prefetch_pkg::CFG_TOP);

  // Request word built for the link side
  always_comb begin
    in_if.data         = '0;
    in_if.data.addr    = req_addr;
    in_if.data.cfg     = is_cfg;
    in_if.data.predict = ~ctl_q[prefetch_pkg::BIT_NOPRED];
    in_if.data.disc1   = is_mr & (mode == prefetch_pkg::PF_ALL);
    if (conv) begin
      in_if.data.addr[0] = 1'b0;
      in_if.data.type1   = 1'b1;
    end else begin
      in_if.data.type1   = is_cfg & (req_addr[1:0] == 2'h1);
    end
    if (full) begin
      in_if.data.len = prefetch_pkg::max_len(ctl_q[prefetch_pkg::MBC_LSB +: 3]);
    end else if (in_win && !in_if.data.disc1) begin
      in_if.data.len = prefetch_pkg::LEN_LINE;
    end else begin
      in_if.data.len = prefetch_pkg::LEN_DW;
    end
  end

  // Repeat of a pending delayed transaction
  assign match = dly_v_q & (req_addr == dly_addr_q) & (req_be == dly_be_q);
  assign hit   = match & ((req_cmd == dly_cmd_q)
               | (ctl_q[prefetch_pkg::BIT_SDR] & is_mem & dly_is_mem));
  assign fwd   = req_valid & ~match & in_if.ready;

  assign in_if.valid = req_valid & ~match;
  assign req_ready   = match | in_if.ready;
  assign out_if.ready = rd_ready;
  assign rd_valid    = out_if.valid;
  assign rd_addr     = out_if.data.addr;
  assign rd_len      = out_if.data.len;
  assign rd_type1    = out_if.data.type1;
  assign rd_cfg      = out_if.data.cfg;
  assign rd_predict  = out_if.data.predict;
  assign rd_disc1    = out_if.data.disc1;

  // Retry or completion answer, one cycle after the repeat
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      retry_pulse <= 1'b0;
      hit_pulse   <= 1'b0;
    end else begin
      retry_pulse <= req_valid & match & ~hit;
      hit_pulse   <= req_valid & hit;
    end
  end

  // Delayed transaction entry
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dly_v_q    <= 1'b0;
      dly_cmd_q  <= 4'h0;
      dly_addr_q <= 32'h0000_0000;
      dly_be_q   <= 4'h0;
      dly_mode_q <= 2'h0;
      dly_full_q <= 1'b0;
    end else if (fwd) begin
      dly_v_q    <= 1'b1;
      dly_cmd_q  <= req_cmd;
      dly_addr_q <= req_addr;
      dly_be_q   <= req_be;
      dly_mode_q <= (is_mrm | is_mrl) ? mode : prefetch_pkg::PF_LINE;
      dly_full_q <= full;
    end else if (xfer_end) begin
      dly_v_q    <= 1'b0;
    end
  end

  // Whether leftover data is kept after the transfer ends
  always_comb begin
    keep = 1'b0;
    if (xfer_end && dly_v_q && dly_full_q) begin
      if (dly_mode_q == prefetch_pkg::PF_ALL) begin
        keep = 1'b1;
      end else if (dly_mode_q == prefetch_pkg::PF_KEEP) begin
        keep = (dly_cmd_q == prefetch_pkg::CMD_MRM) ? ~end_by_master
                                                    : end_by_master;
      end
    end
  end

  assign expire = ret_q & (tmr_q == 32'(DISCARD_CYCLES - 1));

  // Discard timer for retained data
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ret_q <= 1'b0;
      tmr_q <= 32'h0000_0000;
    end else if (keep) begin
      ret_q <= 1'b1;
      tmr_q <= 32'h0000_0000;
    end else if (expire || fwd) begin
      ret_q <= 1'b0;
    end else if (ret_q) begin
      tmr_q <= tmr_q + 32'h0000_0001;
    end
  end

  // Expiry strobe and sticky status; a new expiry beats a clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      discard_pulse <= 1'b0;
      tmo_q         <= 1'b0;
    end else begin
      discard_pulse <= expire;
      if (expire) begin
        tmo_q <= 1'b1;
      end else if (wr_en && ap_addr_q == prefetch_pkg::OFF_STAT
                   && hwdata[prefetch_pkg::STAT_TMO]) begin
        tmo_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_ctl_write;
    wr_en && ap_addr_q == prefetch_pkg::OFF_CTL;
  endsequence

  property p_predict;
    in_if.valid |-> in_if.data.predict == !ctl_q[prefetch_pkg::BIT_NOPRED];
  endproperty
  a_predict: assert property (p_predict) else $error("prediction flag wrong");

  property p_conv;
    in_if.valid && is_cfg && ctl_q[3] && req_addr[31:28] == 4'hF
      |-> in_if.data.type1 && !in_if.data.addr[0];
  endproperty
  a_conv: assert property (p_conv) else $error("config not turned to Type 1");

  property p_line;
    in_if.valid && in_win && (is_mrm || is_mrl || is_mr) && mode == 2'h0
      |-> in_if.data.len == 13'h0040;
  endproperty
  a_line: assert property (p_line) else $error("one line prefetch length wrong");

  property p_first_dw;
    in_if.valid && is_mr && ctl_q[9:8] == 2'h3
      |-> in_if.data.disc1 && in_if.data.len == 13'h0004;
  endproperty
  a_first_dw: assert property (p_first_dw) else $error("first dword disconnect missing");

  property p_retry;
    req_valid && match && req_cmd != dly_cmd_q && !ctl_q[10] |=> retry_pulse && !hit_pulse;
  endproperty
  a_retry: assert property (p_retry) else $error("changed command not retried");

  property p_special;
    req_valid && match && ctl_q[10] && is_mem && dly_is_mem |=> hit_pulse && !retry_pulse;
  endproperty
  a_special: assert property (p_special) else $error("special read not completed");

  property p_malformed;
    s_ctl_write |=> malformed_chk_en == $past(hwdata[prefetch_pkg::BIT_MAL]);
  endproperty
  a_malformed: assert property (p_malformed) else $error("malformed check enable wrong");

  property p_cap;
    in_if.valid && full && ctl_q[14:12] == 3'h6 |-> in_if.data.len == 13'h1000;
  endproperty
  a_cap: assert property (p_cap) else $error("byte count cap wrong");

  property p_keep_all;
    xfer_end && dly_v_q && dly_full_q && dly_mode_q == 2'h3 |=> ret_q && tmr_q == 32'h0;
  endproperty
  a_keep_all: assert property (p_keep_all) else $error("leftover data not kept");

  property p_expire;
    expire |=> discard_pulse && tmo_q && !ret_q;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry not reported");
endmodule

/* File: core/prefetch_pkg.sv */
package prefetch_pkg;
  // Register byte addresses
  localparam logic [7:0] OFF_CTL    = 8'h40;
  localparam logic [7:0] OFF_WBASE  = 8'h44;
  localparam logic [7:0] OFF_WLIMIT = 8'h48;
  localparam logic [7:0] OFF_STAT   = 8'h4C;

  // Values after reset; read multiple field starts at full prefetch
  localparam logic [31:0] CTL_RST    = 32'h0000_0020;
  localparam logic [31:0] CTL_MASK   = 32'h0000_7FFF;
  localparam logic [31:0] WBASE_RST  = 32'h0000_0000;
  localparam logic [31:0] WLIMIT_RST = 32'h0000_0000;

  // Control field positions
  localparam int BIT_NOPRED = 2;
  localparam int BIT_CONV   = 3;
  localparam int MRM_LSB    = 4;
  localparam int MRL_LSB    = 6;
  localparam int MR_LSB     = 8;
  localparam int BIT_SDR    = 10;
  localparam int BIT_MAL    = 11;
  localparam int MBC_LSB    = 12;
  localparam int STAT_TMO   = 0;
  localparam int STAT_RET   = 1;

  // PCI command codes
  localparam logic [3:0] CMD_MR  = 4'h6;
  localparam logic [3:0] CMD_MRL = 4'hE;
  localparam logic [3:0] CMD_MRM = 4'hC;
  localparam logic [2:0] CMD_CFG = 3'h5;
  localparam logic [3:0] CFG_TOP = 4'hF;

  // Prefetch field codes
  localparam logic [1:0] PF_LINE = 2'h0;
  localparam logic [1:0] PF_KEEP = 2'h1;
  localparam logic [1:0] PF_FULL = 2'h2;
  localparam logic [1:0] PF_ALL  = 2'h3;

  // Request lengths in bytes
  localparam logic [12:0] LEN_DW   = 13'h0004;
  localparam logic [12:0] LEN_LINE = 13'h0040;
  localparam logic [12:0] LEN_128  = 13'h0080;
  localparam logic [12:0] LEN_256  = 13'h0100;
  localparam logic [12:0] LEN_512  = 13'h0200;
  localparam logic [12:0] LEN_1K   = 13'h0400;
  localparam logic [12:0] LEN_2K   = 13'h0800;
  localparam logic [12:0] LEN_4K   = 13'h1000;

  // Discard timer length in PCI clocks
  localparam int unsigned DISCARD_CYCLES_DEF = 32768;

  typedef struct packed {
    logic [31:0] addr;
    logic [12:0] len;
    logic        type1;
    logic        cfg;
    logic        predict;
    logic        disc1;
  } rd_req_t;

  // Byte count field decode
  function automatic logic [12:0] max_len(input logic [2:0] code);
    unique case (code)
      3'h1:    max_len = LEN_128;
      3'h2:    max_len = LEN_256;
      3'h4:    max_len = LEN_1K;
      3'h5:    max_len = LEN_2K;
      3'h6:    max_len = LEN_4K;
      default: max_len = LEN_512;
    endcase
  endfunction
endpackage

/* File: core/rd_req_if.sv */
`timescale 1ns/100ps
interface rd_req_if;
  logic                     valid;
  logic                     ready;
  prefetch_pkg::rd_req_t    data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: core/req_buf2.sv */
`timescale 1ns/100ps
module req_buf2 (
  input wire logic sys_clk,
  input wire logic nrst,
  rd_req_if.snk    enq,
  rd_req_if.src    deq
);
  prefetch_pkg::rd_req_t mem_q [2];
  logic [1:0]            cnt_q;
  logic                  rd_ptr_q;
  logic                  wr_ptr_q;
  logic                  push;
  logic                  pop;

  // Honest full and empty flags
  assign enq.ready = (cnt_q != 2'h2);
  assign deq.valid = (cnt_q != 2'h0);
  assign deq.data  = mem_q[rd_ptr_q];
  assign push      = enq.valid & enq.ready;
  assign pop       = deq.valid & deq.ready;

  // Storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= enq.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cnt_q    <= 2'h0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  property p_no_overflow;
    @(posedge sys_clk) disable iff (!nrst)
      cnt_q == 2'h2 && !pop |=> cnt_q == 2'h2;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("buffer lost an entry");
endmodule

/* File: verification/link_model.sv */
`timescale 1ns/100ps
// Upstream link side: accepts read requests, can answer promptly, slowly or stall
module link_model (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  rd_valid,
  input  wire prefetch_pkg::rd_req_t req,
  input  wire logic                  hold,
  input  wire logic                  slow,
  output logic                       rd_ready
);
  logic                  ph_q;
  prefetch_pkg::rd_req_t got_q[$];

  // Ready each cycle, every other cycle when slow, never while held
  assign rd_ready = !hold && (!slow || ph_q);

  // Phase toggle and capture of each accepted request
  always @(posedge sys_clk) begin
    if (!nrst) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      if (rd_valid && rd_ready) begin
        got_q.push_back(req);
      end
    end
  end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
  localparam int         DC    = 16;
  localparam logic [3:0] C_MR  = prefetch_pkg::CMD_MR;
  localparam logic [3:0] C_MRL = prefetch_pkg::CMD_MRL;
  localparam logic [3:0] C_MRM = prefetch_pkg::CMD_MRM;
  localparam logic [31:0] A_CTL = 32'h0000_0040;
  localparam logic [31:0] A_WB  = 32'h0000_0044;
  localparam logic [31:0] A_WL  = 32'h0000_0048;
  localparam logic [31:0] A_ST  = 32'h0000_004C;
  logic        sys_clk, nrst, hsel, hwrite, req_valid, xfer_end, end_by_master;
  logic        hold, slow, hreadyout, hresp, req_ready, retry_pulse, hit_pulse;
  logic        rd_valid, rd_ready, rd_type1, rd_cfg, rd_predict, rd_disc1, seen;
  logic        malformed_chk_en, discard_pulse;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  req_cmd, req_be;
  logic [12:0] rd_len;
  logic [31:0] haddr, hwdata, hrdata, req_addr, rd_addr, d, na;
  int          fail_count, n_tests;
  prefetch_pkg::rd_req_t last;
  // Byte count decode and retention table
  logic [12:0] bc[8] = '{13'h200, 13'h080, 13'h100, 13'h200, 13'h400, 13'h800, 13'h1000, 13'h200};
  logic [3:0]  lk[3] = '{C_MRM, C_MRL, C_MR};
  logic [31:0] rc[6] = '{32'h10, 32'h10, 32'h30, 32'h40, 32'h40, 32'hC0};
  logic [3:0]  rk[6] = '{C_MRM, C_MRM, C_MRM, C_MRL, C_MRL, C_MRL};
  logic [5:0]  eb    = 6'b001110;
  logic [5:0]  ex    = 6'b101101;

  read_prefetch_ctl #(.DISCARD_CYCLES(DC)) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_be(req_be), .req_ready(req_ready),
    .xfer_end(xfer_end), .end_by_master(end_by_master), .retry_pulse(retry_pulse),
    .hit_pulse(hit_pulse), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_addr(rd_addr), .rd_len(rd_len), .rd_type1(rd_type1), .rd_cfg(rd_cfg),
    .rd_predict(rd_predict), .rd_disc1(rd_disc1),
    .malformed_chk_en(malformed_chk_en), .discard_pulse(discard_pulse)
  );

  link_model lm (
    .sys_clk(sys_clk), .nrst(nrst), .rd_valid(rd_valid), .hold(hold), .slow(slow),
    .req({rd_addr, rd_len, rd_type1, rd_cfg, rd_predict, rd_disc1}), .rd_ready(rd_ready)
  );

  // Clock, 4 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  // Single AHB-Lite transfer; read data lands in d
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  // PCI side request, held until taken
  task automatic send(input logic [3:0] c, input logic [31:0] a);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    do @(posedge sys_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask

  // Forwarded request: wait for the link to take it, check its length
  task automatic fwd(input logic [3:0] c, input logic [31:0] a, input logic [12:0] el);
    send(c, a);
    for (int i = 0; i < 20 && lm.got_q.size() == 0; i++) @(posedge sys_clk);
    if (lm.got_q.size() == 0) last = '0;
    else last = lm.got_q.pop_front();
    chk32({19'h0, last.len}, {19'h0, el});
  endtask

  // Same, at a fresh address inside the window
  task automatic fw(input logic [3:0] c, input logic [12:0] el);
    fwd(c, na, el);
    na = na + 32'h40;
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #100000;
    fail_count++;
    summarize();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    req_valid = 1'b0;
    req_cmd = 4'h0;
    req_addr = 32'h0;
    req_be = 4'hF;
    xfer_end = 1'b0;
    end_by_master = 1'b0;
    hold = 1'b0;
    slow = 1'b0;
    fail_count = 0;
    n_tests = 0;
    na = 32'h1000;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset values, masking and unmapped space
    ahb(1'b0, A_CTL, 32'h0);
    chk32(d, 32'h20);
    chk1(hresp, 1'b0);
    chk1(malformed_chk_en, 1'b0);
    ahb(1'b0, A_ST, 32'h0);
    chk32(d, 32'h0);
    ahb(1'b1, 32'h80, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h80, 32'h0);
    chk32(d, 32'h0);
    // A write whose low byte hits the control word but upper bits are set must not land
    ahb(1'b1, 32'h140, 32'h0);
    ahb(1'b0, A_CTL, 32'h0);
    chk32(d, 32'h20);
    ahb(1'b1, A_CTL, 32'hFFFF_FFFF);
    ahb(1'b0, A_CTL, 32'h0);
    chk32(d, 32'h7FFF);
    chk1(malformed_chk_en, 1'b1);
    ahb(1'b1, A_WB, 32'h1000);
    ahb(1'b1, A_WL, 32'h1FFF);
    ahb(1'b0, A_WB, 32'h0);
    chk32(d, 32'h1000);
    // Every byte count code under full prefetch
    for (int k = 0; k < 8; k++) begin
      ahb(1'b1, A_CTL, {17'h0, 3'(k), 12'h200});
      fw(C_MR, bc[k]);
    end
    chk1(last.predict, 1'b1);
    // One line versus full prefetch for each read command
    for (int c = 0; c < 3; c++) begin
      ahb(1'b1, A_CTL, 32'h1000);
      fw(lk[c], 13'h40);
      ahb(1'b1, A_CTL, 32'h1000 | (32'h2 << (4 + 2 * c)));
      fw(lk[c], 13'h80);
    end
    fwd(C_MRM, 32'h8000, 13'h4);
    ahb(1'b1, A_CTL, 32'h300);
    fw(C_MR, 13'h4);
    chk1(last.disc1, 1'b1);
    ahb(1'b1, A_CTL, 32'h4);
    fw(C_MR, 13'h40);
    chk1(last.predict, 1'b0);
    // Configuration conversion on and off
    ahb(1'b1, A_CTL, 32'h8);
    fwd(4'hA, 32'hF000_0101, 13'h4);
    chk1(last.type1, 1'b1);
    chk1(last.cfg, 1'b1);
    chk32(last.addr, 32'hF000_0100);
    ahb(1'b1, A_CTL, 32'h0);
    fwd(4'hA, 32'hF000_0200, 13'h4);
    chk1(last.type1, 1'b0);
    // Changed command on repeat: retried, then completed in special mode
    ahb(1'b1, A_CTL, 32'h20);
    fwd(C_MRM, 32'h1800, 13'h200);
    send(C_MR, 32'h1800);
    @(posedge sys_clk);
    chk1(retry_pulse, 1'b1);
    ahb(1'b1, A_CTL, 32'h420);
    send(C_MR, 32'h1800);
    @(posedge sys_clk);
    chk1(hit_pulse, 1'b1);
    chk32(32'(lm.got_q.size()), 32'h0);
    // Retention by mode and ending party, discard and sticky status
    for (int i = 0; i < 6; i++) begin
      ahb(1'b1, A_CTL, rc[i]);
      fw(rk[i], 13'h200);
      @(posedge sys_clk);
      xfer_end <= 1'b1;
      end_by_master <= eb[i];
      @(posedge sys_clk);
      xfer_end <= 1'b0;
      ahb(1'b0, A_ST, 32'h0);
      chk32(d, {30'h0, ex[i], 1'b0});
      seen = 1'b0;
      repeat (DC + 8) begin
        @(posedge sys_clk);
        if (discard_pulse === 1'b1) seen = 1'b1;
      end
      chk1(seen, ex[i]);
      ahb(1'b0, A_ST, 32'h0);
      chk32(d, {31'h0, ex[i]});
      ahb(1'b1, A_ST, 32'h1);
      ahb(1'b0, A_ST, 32'h0);
      chk32(d, 32'h0);
    end
    // Fill the buffer against a stalled link, then drain it slowly
    hold <= 1'b1;
    send(C_MRM, 32'h1A00);
    send(C_MRM, 32'h1A40);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_addr <= 32'h1A80;
    repeat (3) @(posedge sys_clk);
    chk1(req_ready, 1'b0);
    hold <= 1'b0;
    slow <= 1'b1;
    do @(posedge sys_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk32(32'(lm.got_q.size()), 32'h3);
    chk1(rd_valid, 1'b0);
    summarize();
  end
endmodule
